/* File: src/fmb_read_port.sv */
// Muxed address/data flash read port: command latches, asynchronous reads,
// and clocked burst reads with initial latency and group-crossing waits.
// Assumes host pins change on core_clk, so they are used without synchronisers.
// Behaviour
// - Operations start by command writes into latches
// - Command latches never alias readable array words
// - Bad sequence sticks; reset command returns read
// - Asynchronous address captured on strobe rising edge
// - Drive word once output access time elapses
// - Clock edge with strobe low starts burst
// - Burst words advance one per rising edge
// - Ready low marks initial burst latency
// - No extra latency crossing 128-word lines
// - Insert start-dependent waits after first group
// - Chip select high ends burst, floats outputs
// - Hardware reset ends burst, floats outputs
// - New strobed address aborts and restarts burst
`timescale 1ns/100ps
module fmb_read_port (
  // Clock and hardware reset
  input  wire logic                          core_clk,
  input  wire logic                          arst_n,
  // Host strobes
  input  wire logic                          cs_n,
  input  wire logic                          oe_n,
  input  wire logic                          we_n,
  input  wire logic                          addr_valid_strobe_n,
  // Address and data
  input  wire logic [fmb_pkg::UPPER_W-1:0]   upper_address,
  input  wire logic [fmb_pkg::MUX_W-1:0]     muxed_addr_data_in,
  output logic      [fmb_pkg::MUX_W-1:0]     muxed_addr_data_out,
  output logic                               muxed_addr_data_oe,
  // Ready
  output logic                               rdy,
  output logic                               rdy_oe,
  // Configuration status
  output logic [3:0]                         wait_states,
  output logic                               burst_mode
);
  fmb_mem_if mem_bus ();

  fmb_array u_array (
    .core_clk (core_clk),
    .bus      (mem_bus.mem)
  );

  fmb_pkg::fmb_burst_e        state, next_state;
  fmb_pkg::fmb_cmd_e          cmd, next_cmd;
  logic [fmb_pkg::ADDR_W-1:0] addr, next_addr;
  logic [3:0]                 lat_cnt, next_lat_cnt;
  logic [3:0]                 extra, next_extra;
  logic                       first_grp, next_first_grp;
  logic [3:0]                 wait_cfg, next_wait_cfg;
  logic                       burst_en, next_burst_en;
  logic                       avd_q, we_q, oe_q;
  logic [1:0]                 oe_cnt, next_oe_cnt;

  logic [fmb_pkg::ADDR_W-1:0] bus_addr;
  logic                       avd_rise, we_rise, oe_fall;
  logic                       latch_clk, latch_async, burst_go, wr_strobe;
  logic [4:0]                 start_sum;
  logic [3:0]                 start_extra;
  logic                       group_end;

  assign bus_addr    = {upper_address, muxed_addr_data_in};
  assign avd_rise    = !avd_q && addr_valid_strobe_n;
  assign we_rise     = !we_q && we_n;
  assign oe_fall     = oe_q && !oe_n;
  assign latch_clk   = !cs_n && !addr_valid_strobe_n && burst_en;
  assign latch_async = !cs_n && avd_rise && !burst_en;
  assign burst_go    = latch_clk && we_n;
  assign wr_strobe   = !cs_n && we_rise;
  // Waits after the first group: start word plus wait count beyond nine
  assign start_sum   = {2'h0, muxed_addr_data_in[2:0]} + {1'b0, wait_cfg};
  assign start_extra = (start_sum > fmb_pkg::WS_LIMIT) ? 4'(start_sum - fmb_pkg::WS_LIMIT) : 4'h0;
  assign group_end   = first_grp && (addr[2:0] == fmb_pkg::GROUP_LAST);

  // Burst sequencer
  always_comb begin
    next_state     = state;
    next_addr      = addr;
    next_lat_cnt   = lat_cnt;
    next_extra     = extra;
    next_first_grp = first_grp;
    if (cs_n) begin
      next_state = fmb_pkg::st_idle;
    end else if (burst_go) begin
      next_addr      = bus_addr;
      next_state     = fmb_pkg::st_lat;
      next_lat_cnt   = wait_cfg;
      next_extra     = start_extra;
      next_first_grp = 1'b1;
    end else if (latch_clk || latch_async) begin
      next_addr = bus_addr;
    end else begin
      case (state)
        fmb_pkg::st_lat: begin
          if (lat_cnt <= 4'h1) begin
            next_state = fmb_pkg::st_stream;
          end else begin
            next_lat_cnt = lat_cnt - 4'h1;
          end
        end
        fmb_pkg::st_stream: begin
          if (group_end) begin
            next_first_grp = 1'b0;
          end
          if (group_end && extra != 4'h0) begin
            next_state = fmb_pkg::st_gap;
          end else begin
            next_addr = addr + fmb_pkg::ADDR_W'(1);
          end
        end
        fmb_pkg::st_gap: begin
          if (extra <= 4'h1) begin
            next_addr  = addr + fmb_pkg::ADDR_W'(1);
            next_state = fmb_pkg::st_stream;
          end else begin
            next_extra = extra - 4'h1;
          end
        end
        default: next_state = fmb_pkg::st_idle;
      endcase
    end
  end

  // Command latches and configuration; the array is only written via a program sequence
  always_comb begin
    next_cmd        = cmd;
    next_wait_cfg   = wait_cfg;
    next_burst_en   = burst_en;
    mem_bus.wr_en   = 1'b0;
    mem_bus.wr_addr = addr[fmb_pkg::MEM_AW-1:0];
    mem_bus.wr_data = muxed_addr_data_in;
    if (wr_strobe) begin
      if (muxed_addr_data_in[7:0] == fmb_pkg::CMD_RESET) begin
        next_cmd = fmb_pkg::cmd_read;
      end else begin
        case (cmd)
          fmb_pkg::cmd_read: begin
            if (addr[11:0] == fmb_pkg::UNLOCK_ADR1 && muxed_addr_data_in[7:0] == fmb_pkg::CMD_UNLOCK1) begin
              next_cmd = fmb_pkg::cmd_u1;
            end
          end
          fmb_pkg::cmd_u1: begin
            if (addr[11:0] == fmb_pkg::UNLOCK_ADR2 && muxed_addr_data_in[7:0] == fmb_pkg::CMD_UNLOCK2) begin
              next_cmd = fmb_pkg::cmd_u2;
            end else begin
              next_cmd = fmb_pkg::cmd_stuck;
            end
          end
          fmb_pkg::cmd_u2: begin
            if (muxed_addr_data_in[7:0] == fmb_pkg::CMD_PROGRAM) begin
              next_cmd = fmb_pkg::cmd_prog;
            end else if (muxed_addr_data_in[7:0] == fmb_pkg::CMD_CONFIG) begin
              next_cmd = fmb_pkg::cmd_cfg;
            end else begin
              next_cmd = fmb_pkg::cmd_stuck;
            end
          end
          fmb_pkg::cmd_prog: begin
            mem_bus.wr_en = 1'b1;
            next_cmd      = fmb_pkg::cmd_read;
          end
          fmb_pkg::cmd_cfg: begin
            next_wait_cfg = muxed_addr_data_in[fmb_pkg::CFG_WAIT_LSB +: 4];
            next_burst_en = muxed_addr_data_in[fmb_pkg::CFG_BURST_BIT];
            next_cmd      = fmb_pkg::cmd_read;
          end
          fmb_pkg::cmd_stuck: next_cmd = fmb_pkg::cmd_stuck;
          default: next_cmd = fmb_pkg::cmd_read;
        endcase
      end
    end
  end

  // Output access delay counted from the output enable falling edge
  always_comb begin
    next_oe_cnt = oe_cnt;
    if (oe_n) begin
      next_oe_cnt = 2'h0;
    end else if (oe_fall) begin
      next_oe_cnt = fmb_pkg::OE_LOAD;
    end else if (oe_cnt != 2'h0) begin
      next_oe_cnt = oe_cnt - 2'h1;
    end
  end

  // Reset ends any burst and releases every pin
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= fmb_pkg::st_idle;
      cmd       <= fmb_pkg::cmd_read;
      addr      <= '0;
      lat_cnt   <= 4'h0;
      extra     <= 4'h0;
      first_grp <= 1'b0;
      wait_cfg  <= fmb_pkg::WAIT_DEF;
      burst_en  <= 1'b0;
      avd_q     <= 1'b1;
      we_q      <= 1'b1;
      oe_q      <= 1'b1;
      oe_cnt    <= 2'h0;
    end else begin
      state     <= next_state;
      cmd       <= next_cmd;
      addr      <= next_addr;
      lat_cnt   <= next_lat_cnt;
      extra     <= next_extra;
      first_grp <= next_first_grp;
      wait_cfg  <= next_wait_cfg;
      burst_en  <= next_burst_en;
      avd_q     <= addr_valid_strobe_n;
      we_q      <= we_n;
      oe_q      <= oe_n;
      oe_cnt    <= next_oe_cnt;
    end
  end

  // Read address runs one edge ahead so array data track addr
  assign mem_bus.rd_addr     = next_addr[fmb_pkg::MEM_AW-1:0];
  assign muxed_addr_data_out = (cmd == fmb_pkg::cmd_stuck) ? fmb_pkg::STATUS_WORD : mem_bus.rd_data;
  // Hardware reset floats the pins whatever the host strobes are doing
  assign muxed_addr_data_oe  = arst_n && !cs_n && !oe_n && we_n && !oe_fall && oe_cnt == 2'h0;
  assign rdy    = !(state == fmb_pkg::st_lat || state == fmb_pkg::st_gap);
  assign rdy_oe = arst_n && !cs_n;
  assign wait_states = wait_cfg;
  assign burst_mode  = burst_en;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_start;
    burst_go;
  endsequence
  sequence s_oe_hold;
    oe_fall && !cs_n && we_n ##1 !oe_n && !cs_n && we_n;
  endsequence

  property p_rdy_latency;
    s_start |=> !rdy;
  endproperty
  a_rdy_latency: assert property (p_rdy_latency) else $error("ready not low after burst start");

  property p_burst_addr;
    s_start |=> addr == $past(bus_addr);
  endproperty
  a_burst_addr: assert property (p_burst_addr) else $error("burst start address not captured");

  property p_abort;
    ((state == fmb_pkg::st_stream) and s_start) |=> state == fmb_pkg::st_lat && !rdy;
  endproperty
  a_abort: assert property (p_abort) else $error("new address did not restart burst");

  property p_inc;
    (state == fmb_pkg::st_stream && !cs_n && !latch_clk && !(group_end && extra != 4'h0))
      |=> addr == $past(addr) + fmb_pkg::ADDR_W'(1) && rdy;
  endproperty
  a_inc: assert property (p_inc) else $error("burst address did not advance");

  property p_gap;
    (state == fmb_pkg::st_gap && !cs_n && !latch_clk && extra > 4'h1) |=> $stable(addr) && !rdy;
  endproperty
  a_gap: assert property (p_gap) else $error("group wait cycle not held");

  property p_line;
    (state == fmb_pkg::st_stream && addr[6:0] == fmb_pkg::LINE_LAST && !first_grp && !cs_n && !latch_clk)
      |=> state == fmb_pkg::st_stream && rdy;
  endproperty
  a_line: assert property (p_line) else $error("latency added at line boundary");

  property p_cs_float;
    cs_n |-> !muxed_addr_data_oe && !rdy_oe ##1 state == fmb_pkg::st_idle;
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("outputs driven while deselected");

  property p_async;
    latch_async |=> addr == $past(bus_addr);
  endproperty
  a_async: assert property (p_async) else $error("strobe rising edge did not capture address");

  property p_oe_wait;
    s_oe_hold |-> muxed_addr_data_oe ##0 $past(!muxed_addr_data_oe);
  endproperty
  a_oe_wait: assert property (p_oe_wait) else $error("data not driven after access time");

  property p_reset_cmd;
    (wr_strobe && muxed_addr_data_in[7:0] == fmb_pkg::CMD_RESET) |=> cmd == fmb_pkg::cmd_read;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command did not restore read mode");

  property p_prog_only;
    mem_bus.wr_en |-> cmd == fmb_pkg::cmd_prog && wr_strobe ##1 cmd == fmb_pkg::cmd_read;
  endproperty
  a_prog_only: assert property (p_prog_only) else $error("array written outside program sequence");
endmodule

/* File: src/fmb_pkg.sv */
// Shared constants for the muxed-bus flash read port: widths, command codes,
// burst latency limits and pin timing.
// Assumes a single 10 MHz core clock that is also the host burst clock.
package fmb_pkg;

  // Bus and array geometry
  localparam int unsigned MUX_W   = 16;
  localparam int unsigned UPPER_W = 4;
  localparam int unsigned ADDR_W  = MUX_W + UPPER_W;
  localparam int unsigned MEM_AW  = 10;

  // Burst group and line geometry, wait limits and configuration fields
  localparam logic [2:0] GROUP_LAST = 3'h7;
  localparam logic [6:0] LINE_LAST  = 7'h7f;
  localparam logic [4:0] WS_LIMIT   = 5'h09;
  localparam logic [3:0] WAIT_DEF   = 4'h9;
  localparam int unsigned CFG_WAIT_LSB = 0;
  localparam int unsigned CFG_BURST_BIT = 4;

  // Command codes and unlock addresses
  localparam logic [7:0]  CMD_RESET   = 8'hf0;
  localparam logic [7:0]  CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM = 8'ha0;
  localparam logic [7:0]  CMD_CONFIG  = 8'h60;
  localparam logic [11:0] UNLOCK_ADR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADR2 = 12'h2aa;

  // Word shown while the command machine is stuck; value is arbitrary
  localparam logic [MUX_W-1:0] STATUS_WORD = 16'h0080;

  // Output access time after output enable falls
  localparam int unsigned CLK_PERIOD_NS        = 100;
  localparam int unsigned OUTPUT_ACCESS_TIME_NS = 20;
  localparam int unsigned OE_CYC_RAW = (OUTPUT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OE_CYC     = (OE_CYC_RAW < 1) ? 1 : OE_CYC_RAW;
  localparam logic [1:0]  OE_LOAD    = 2'(OE_CYC - 1);

  typedef enum logic [2:0] {st_idle, st_lat, st_stream, st_gap} fmb_burst_e;
  typedef enum logic [2:0] {cmd_read, cmd_u1, cmd_u2, cmd_prog, cmd_cfg, cmd_stuck} fmb_cmd_e;

endpackage

/* File: src/fmb_mem_if.sv */
// Carrier between the read port logic and its word array.
// Assumes one clock; read data lag the read address by one edge.
`timescale 1ns/100ps
interface fmb_mem_if;
  logic [fmb_pkg::MEM_AW-1:0] rd_addr;
  logic [fmb_pkg::MUX_W-1:0]  rd_data;
  logic                       wr_en;
  logic [fmb_pkg::MEM_AW-1:0] wr_addr;
  logic [fmb_pkg::MUX_W-1:0]  wr_data;

  modport port (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport mem  (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

/* File: src/fmb_array.sv */
// Word array behind the read port, with registered read data.
// Assumes the port presents next-cycle read addresses; contents are not reset.
`timescale 1ns/100ps
module fmb_array (
  // Clock
  input wire logic core_clk,
  // Access
  fmb_mem_if.mem   bus
);
  logic [fmb_pkg::MUX_W-1:0] store [0:(1<<fmb_pkg::MEM_AW)-1];
  logic [fmb_pkg::MUX_W-1:0] rd_q;

  always_ff @(posedge core_clk) begin
    if (bus.wr_en) begin
      store[bus.wr_addr] <= bus.wr_data;
    end
    rd_q <= store[bus.rd_addr];
  end

  assign bus.rd_data = rd_q;
endmodule

/* File: dv/fmb_host_model.sv */
// Host controller model: drives strobes, upper address and the shared bus.
// Assumes callers sequence tasks on core_clk; every pin moves by NBA after an edge.
`timescale 1ns/100ps
module fmb_host_model (
  // Clock
  input  wire logic                   core_clk,
  // Strobes
  output logic                        cs_n,
  output logic                        oe_n,
  output logic                        we_n,
  output logic                        addr_valid_strobe_n,
  // Address and data
  output logic [fmb_pkg::UPPER_W-1:0] upper_address,
  output logic [fmb_pkg::MUX_W-1:0]   bus_val
);
  initial begin
    {cs_n, oe_n, we_n, addr_valid_strobe_n} = 4'hf;
    {upper_address, bus_val} = 20'h00000;
  end
  // ctl is {cs_n, oe_n, we_n, strobe}; a released bus shows the inverse so stale data never matches
  task automatic drive(input logic [3:0] ctl, input logic [19:0] v, input bit rel);
    @(posedge core_clk);
    {cs_n, oe_n, we_n, addr_valid_strobe_n} <= ctl;
    {upper_address, bus_val} <= rel ? {upper_address, ~bus_val} : v;
  endtask
  task automatic write_word(input logic [19:0] a, input logic [15:0] d);
    // Address must still stand while the strobe rises, and write enable stays low so no burst starts
    drive(4'h4, a, 1'h0);
    drive(4'h5, a, 1'h0);
    drive(4'h7, {4'h0, d}, 1'h0);
    drive(4'hf, 20'h00000, 1'h1);
  endtask
  task automatic async_read_start(input logic [19:0] a);
    drive(4'h6, a, 1'h0);
    drive(4'h7, a, 1'h0);
    drive(4'h3, 20'h00000, 1'h1);
  endtask
  task automatic burst_start(input logic [19:0] a);
    drive(4'h6, a, 1'h0);
    drive(4'h3, 20'h00000, 1'h1);
  endtask
  task automatic deselect();
    drive(4'hf, 20'h00000, 1'h1);
  endtask
endmodule

/* File: dv/test_flash_muxed_bus_read_port.sv */
// Self-checking bench for the muxed-bus flash read port against a word-level reference.
// Assumes the host model owns the strobes; the bench owns clock, reset and the bus wire.
`timescale 1ns/100ps
module test_flash_muxed_bus_read_port;
  logic        core_clk = 1'h0;
  logic        arst_n   = 1'h0;
  logic        cs_n, oe_n, we_n, avd_n, md_oe, rdy, rdy_oe, burst_mode;
  logic [3:0]  up, wait_states;
  logic [15:0] bus_val, md_out, bus_wire;
  logic [15:0] mem_m [int];
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  always #50 core_clk = ~core_clk;
  assign bus_wire = md_oe ? md_out : bus_val;

  fmb_host_model host (.core_clk(core_clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .addr_valid_strobe_n(avd_n), .upper_address(up), .bus_val(bus_val));
  fmb_read_port dut (.core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .addr_valid_strobe_n(avd_n), .upper_address(up), .muxed_addr_data_in(bus_wire),
    .muxed_addr_data_out(md_out), .muxed_addr_data_oe(md_oe), .rdy(rdy), .rdy_oe(rdy_oe),
    .wait_states(wait_states), .burst_mode(burst_mode));

  task automatic check(input bit ok, input string what);
    n_compared++;
    if (!ok) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmd4(input logic [7:0] op, input logic [19:0] a, input logic [15:0] v);
    host.write_word(20'h00555, 16'h00aa);
    host.write_word(20'h002aa, 16'h0055);
    host.write_word(20'h00000, {8'h00, op});
    host.write_word(a, v);
  endtask
  task automatic prog(input logic [19:0] a, input logic [15:0] v);
    cmd4(8'ha0, a, v);
    mem_m[a[9:0]] = v;
  endtask
  task automatic async_chk(input logic [19:0] a, input logic [15:0] exp);
    host.async_read_start(a);
    #1 check(md_oe === 1'h0, "bus driven before access time");
    @(posedge core_clk);
    #1 check(md_oe === 1'h1 && md_out === exp, "async read word");
    host.deselect();
    #1 check(md_oe === 1'h0 && rdy_oe === 1'h0, "outputs not floated");
  endtask
  task automatic run_burst(input logic [19:0] a, input int n, input int len);
    logic        q_r[$];
    logic [15:0] q_d[$];
    int          gap;
    gap = int'(a[2:0]) + n - 9;
    for (int i = 0; i < n; i++) begin
      q_r.push_back(1'h0);
      q_d.push_back(16'h0000);
    end
    for (int i = 0; i < len; i++) begin
      q_r.push_back(1'h1);
      q_d.push_back(mem_m[(a + i) % 1024]);
      // Only the first group crossing waits; later crossings run at full rate
      for (int j = 0; i < 8 && ((a + i) % 8) == 7 && j < gap; j++) begin
        q_r.push_back(1'h0);
        q_d.push_back(16'h0000);
      end
    end
    host.burst_start(a);
    foreach (q_r[i]) begin
      #1 check(rdy === q_r[i] && rdy_oe === 1'h1 && (!q_r[i] || (md_oe === 1'h1 && md_out === q_d[i])),
               "burst word or ready");
      if (i < q_r.size() - 1) @(posedge core_clk);
    end
  endtask

  initial begin
    logic [19:0] a;
    void'($urandom(97845));
    repeat (4) @(posedge core_clk);
    arst_n <= 1'h1;
    #1 check(wait_states === 4'h9 && burst_mode === 1'h0 && md_oe === 1'h0, "reset state");
    $display("test reset done");
    // Unlock addresses are programmed first, then hammered by later unlock writes
    prog(20'h00555, 16'($urandom));
    prog(20'h002aa, 16'($urandom));
    for (int i = 0; i < 'h90; i++) prog(20'(i), 16'($urandom));
    $display("test program done");
    async_chk({4'($urandom), 16'h0555}, mem_m[10'h155]);
    async_chk(20'h002aa, mem_m[10'h2aa]);
    for (int i = 0; i < 6; i++) begin
      a = {4'($urandom), 16'($urandom % 'h90)};
      async_chk(a, mem_m[a[9:0]]);
    end
    $display("test async read done");
    host.write_word(20'h00555, 16'h00aa);
    host.write_word(20'h00123, 16'h0077);
    async_chk(20'h00010, fmb_pkg::STATUS_WORD);
    host.write_word(20'h00000, 16'h00f0);
    async_chk(20'h00010, mem_m[16]);
    $display("test stuck and reset command done");
    for (int n = 2; n <= 9; n++) begin
      cmd4(8'h60, 20'h00000, {11'h000, 1'h1, 4'(n)});
      #1 check(wait_states === 4'(n) && burst_mode === 1'h1, "configuration");
      run_burst({4'($urandom), 16'h0077}, n, 12);
      run_burst(20'h00010 + 20'($urandom % 8), n, 10);
      host.deselect();
      #1 check(md_oe === 1'h0 && rdy_oe === 1'h0, "burst not ended");
    end
    $display("test burst done");
    run_burst(20'h00020, 9, 3);
    @(posedge core_clk);
    arst_n <= 1'h0;
    #1 check(md_oe === 1'h0 && rdy_oe === 1'h0 && rdy === 1'h1, "pins not floated in reset");
    host.deselect();
    #1 check(wait_states === 4'h9 && burst_mode === 1'h0 && rdy === 1'h1, "reset mid burst");
    @(posedge core_clk);
    arst_n <= 1'h1;
    async_chk(20'h00030, mem_m[48]);
    $display("test hardware reset done");
    conclude();
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      $display("MISMATCH at %0t: run did not finish", $time);
      conclude();
    end
  end
endmodule
